// *** hw/fjv_freq_jump.sv ***
// frequency jump (pickup plus change in window) and vector surge protection element
// assumes frequency and voltage words from a front end on clk; zero-crossing pins are async
`timescale 1ns/1ps
module fjv_freq_jump #(
   parameter int FW = 16,
   parameter logic [31:0] DETECT_CYCLES = 32'(fjv_pkg::DETECT_CYC)
)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [FW-1:0] freq_ab,
   input wire logic [FW-1:0] freq_bc,
   input wire logic [FW-1:0] freq_ca,
   input wire logic [15:0] line_voltage_ab,
   input wire logic [15:0] line_voltage_bc,
   input wire logic [15:0] line_voltage_ca,
   input wire logic zc_ab,
   input wire logic zc_bc,
   input wire logic zc_ca,
   input wire logic [2:0] phase_loss,
   input wire logic block_in,
   output logic alarm,
   output logic trip,
   output logic irq
);
   logic [4:0] ctrl_r;
   logic [FW-1:0] pickup_r, freq_change_limit_r, rated_frequency_r;
   logic [15:0] supervision_window_r, lv_thresh_r;
   logic [31:0] surge_thr_r, ref_period_r;
   localparam int INT_W_C = fjv_pkg::INT_W;
   logic [INT_W_C-1:0] int_stat_r, int_mask_r, int_set, evt, evt_d_r;
   logic [31:0] rd_mux;
   logic rd_err;
   fjv_pkg::fjv_state_e st_r;
   logic [FW-1:0] f [3];
   logic [FW-1:0] ref_r [3];
   logic [FW+3:0] hyst_pk, hyst_rt;
   logic [FW-1:0] hyst;
   logic [2:0] pick, held, chg;
   logic [2:0] surge_ph;
   logic [1:0] nsurge;
   logic [47:0] win_cnt_r, win_len;
   logic [1:0] mode;
   logic en, lv_all, blocked, start_c, held_any, chg_hit, expired;
   logic vote_met, surge_ok, surge_r, alarm_r, trip_r;
   logic aw_hold_r, w_hold_r;
   logic [7:0] awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;
   logic do_wr, do_rd, rd_int;
   // ****************************************
   // evaluation gating and dropout thresholds
   // ****************************************
   assign mode = ctrl_r[fjv_pkg::CTRL_MODE_LSB +: 2];
   assign en = ctrl_r[fjv_pkg::CTRL_EN_BIT];
   assign f[0] = freq_ab;
   assign f[1] = freq_bc;
   assign f[2] = freq_ca;
   // combinational so it wins over a surge result on the same edge
   assign lv_all = (line_voltage_ab < lv_thresh_r) && (line_voltage_bc < lv_thresh_r)
                   && (line_voltage_ca < lv_thresh_r);
   assign blocked = lv_all | block_in | ~en;
   assign hyst_pk = ((FW+4)'(pickup_r) * (FW+4)'(fjv_pkg::DROP_NUM))
                    / (FW+4)'(fjv_pkg::DROP_DEN);
   assign hyst_rt = ((FW+4)'(rated_frequency_r) * (FW+4)'(fjv_pkg::DROP_NUM))
                    / (FW+4)'(fjv_pkg::DROP_DEN);
   // larger of the two offsets, so neither dropout figure is undercut
   assign hyst = (hyst_pk > hyst_rt) ? hyst_pk[FW-1:0] : hyst_rt[FW-1:0];
   always_comb
   begin
      for (int i = 0; i < 3; i++)
      begin
         if (mode == fjv_pkg::MODE_OVER)
         begin
            pick[i] = f[i] > pickup_r;
            held[i] = f[i] >= (pickup_r - hyst);
         end
         else
         begin
            pick[i] = f[i] < pickup_r;
            held[i] = f[i] <= (pickup_r + hyst);
         end
         chg[i] = held[i] && (((f[i] > ref_r[i]) ? f[i] - ref_r[i] : ref_r[i] - f[i])
                  >= freq_change_limit_r);
      end
   end
   assign start_c = (mode == fjv_pkg::MODE_UNDER || mode == fjv_pkg::MODE_OVER)
                    && !blocked && (|pick);
   assign held_any = |held;
   assign chg_hit = |chg;
   assign win_len = 48'(supervision_window_r) * 48'(fjv_pkg::CYC_PER_MS);
   assign expired = (win_cnt_r >= win_len);
   // ****************************************
   // jump element state machine
   // ****************************************
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         st_r <= fjv_pkg::FJV_IDLE;
      else
         case (st_r)
            fjv_pkg::FJV_IDLE:
               if (start_c)
                  st_r <= fjv_pkg::FJV_WIN;
            fjv_pkg::FJV_WIN:
               if (!held_any || blocked)
                  st_r <= fjv_pkg::FJV_IDLE;
               else if (chg_hit)
                  st_r <= fjv_pkg::FJV_TRIP;
               else if (expired)
                  st_r <= fjv_pkg::FJV_LOCK;
            fjv_pkg::FJV_TRIP:
               if (!held_any)
                  st_r <= fjv_pkg::FJV_IDLE;
            fjv_pkg::FJV_LOCK:
               if (!held_any)
                  st_r <= fjv_pkg::FJV_IDLE;
            default:
               st_r <= fjv_pkg::FJV_IDLE;
         endcase
   end
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         win_cnt_r <= '0;
      else if (st_r == fjv_pkg::FJV_WIN && !expired)
         win_cnt_r <= win_cnt_r + 48'h1;
      else if (st_r != fjv_pkg::FJV_WIN)
         win_cnt_r <= '0;
   end
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         for (int i = 0; i < 3; i++)
            ref_r[i] <= '0;
      else if (st_r == fjv_pkg::FJV_IDLE && start_c)
         for (int i = 0; i < 3; i++)
            ref_r[i] <= f[i];
   end
   // ****************************************
   // vector surge
   // ****************************************
   fjv_cycle_meter #(.CW(32), .MAX_CYC(DETECT_CYCLES)) u_meter_ab (
      .clk(clk), .rst_n(rst_n), .zc_pin(zc_ab), .ref_period(ref_period_r),
      .surge_thresh(surge_thr_r), .new_meas(), .surge(surge_ph[0]));
   fjv_cycle_meter #(.CW(32), .MAX_CYC(DETECT_CYCLES)) u_meter_bc (
      .clk(clk), .rst_n(rst_n), .zc_pin(zc_bc), .ref_period(ref_period_r),
      .surge_thresh(surge_thr_r), .new_meas(), .surge(surge_ph[1]));
   fjv_cycle_meter #(.CW(32), .MAX_CYC(DETECT_CYCLES)) u_meter_ca (
      .clk(clk), .rst_n(rst_n), .zc_pin(zc_ca), .ref_period(ref_period_r),
      .surge_thresh(surge_thr_r), .new_meas(), .surge(surge_ph[2]));
   // a silent phase saturates its meter, so failure shows within the detect time
   assign nsurge = 2'(surge_ph[0]) + 2'(surge_ph[1]) + 2'(surge_ph[2]);
   always_comb
   begin
      case (ctrl_r[fjv_pkg::CTRL_VOTE_LSB +: 2])
         fjv_pkg::VOTE_ALL: vote_met = (nsurge == 2'h3);
         fjv_pkg::VOTE_TWO: vote_met = (nsurge >= 2'h2);
         default: vote_met = (nsurge != 2'h0);
      endcase
   end
   assign surge_ok = (mode == fjv_pkg::MODE_SURGE) && !blocked && !(|phase_loss);
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         surge_r <= 1'b0;
      else
         surge_r <= vote_met && surge_ok;
   end
   // ****************************************
   // outputs
   // ****************************************
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         alarm_r <= 1'b0;
         trip_r <= 1'b0;
      end
      else
      begin
         alarm_r <= (st_r == fjv_pkg::FJV_IDLE && start_c) || (vote_met && surge_ok)
                    || (st_r == fjv_pkg::FJV_WIN && held_any && !blocked)
                    || (st_r == fjv_pkg::FJV_TRIP && held_any);
         trip_r <= (st_r == fjv_pkg::FJV_WIN && held_any && !blocked && chg_hit)
                   || (st_r == fjv_pkg::FJV_TRIP && held_any)
                   || (vote_met && surge_ok);
      end
   end
   assign alarm = alarm_r;
   assign trip = trip_r;
   AST_TRIP_WITH_ALARM: assert property (@(posedge clk) disable iff (!rst_n)
      trip_r |-> alarm_r) else $error("trip seen without alarm");
   AST_START_ALARM: assert property (@(posedge clk) disable iff (!rst_n)
      (st_r == fjv_pkg::FJV_IDLE && start_c) |=> alarm_r) else $error("pickup gave no alarm");
   AST_WIN_FROM_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
      (st_r == fjv_pkg::FJV_IDLE && start_c) |=> (win_cnt_r == 48'h0)) else $error("window not fresh");
   AST_EXPIRY_NO_TRIP: assert property (@(posedge clk) disable iff (!rst_n)
      (st_r == fjv_pkg::FJV_WIN && expired && !chg_hit && mode != fjv_pkg::MODE_SURGE)
      |=> !trip_r) else $error("trip after window expiry");
   AST_LV_NO_SURGE: assert property (@(posedge clk) disable iff (!rst_n)
      lv_all |=> !surge_r) else $error("surge despite low voltage");
   AST_LOSS_NO_SURGE: assert property (@(posedge clk) disable iff (!rst_n)
      (|phase_loss) |=> !surge_r) else $error("surge despite phase loss");
   AST_DROP_CLEARS: assert property (@(posedge clk) disable iff (!rst_n)
      (st_r == fjv_pkg::FJV_TRIP && !held_any && mode != fjv_pkg::MODE_SURGE)
      |=> (!alarm_r && !trip_r)) else $error("dropout left alarm or trip");
   AST_BVALID_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
      (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid) else $error("write response dropped");
   // ****************************************
   // interrupts, read of status clears
   // ****************************************
   // rising edges only; set wins over a clearing read in the same cycle
   assign evt = {surge_r, st_r == fjv_pkg::FJV_LOCK, trip_r, alarm_r};
   assign int_set = evt & ~evt_d_r;
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         int_stat_r <= '0;
         evt_d_r <= '0;
      end
      else
      begin
         int_stat_r <= (rd_int ? '0 : int_stat_r) | int_set;
         evt_d_r <= evt;
      end
   end
   assign irq = |(int_stat_r & int_mask_r);
   // ****************************************
   // axi4-lite slave
   // ****************************************
   assign s_axi_awready = ~aw_hold_r;
   assign s_axi_wready = ~w_hold_r;
   assign s_axi_arready = ~s_axi_rvalid;
   assign do_wr = aw_hold_r && w_hold_r && !s_axi_bvalid;
   assign do_rd = s_axi_arvalid && !s_axi_rvalid;
   assign rd_int = do_rd && (s_axi_araddr == fjv_pkg::OFF_INT_STAT);
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         aw_hold_r <= 1'b0;
         w_hold_r <= 1'b0;
         awaddr_r <= '0;
         wdata_r <= '0;
         wstrb_r <= '0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
      end
      else
      begin
         if (s_axi_awvalid && !aw_hold_r)
         begin
            aw_hold_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && !w_hold_r)
         begin
            w_hold_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
         end
         if (do_wr)
         begin
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (awaddr_r > fjv_pkg::OFF_INT_MASK || awaddr_r[1:0] != 2'h0
                            || awaddr_r == fjv_pkg::OFF_STATUS) ? 2'h2 : 2'h0;
         end
         else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end
   // ****************************************
   // register writes, any strobe writes the word
   // ****************************************
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ctrl_r <= fjv_pkg::CTRL_RST;
         pickup_r <= FW'(fjv_pkg::PICKUP_RST);
         freq_change_limit_r <= FW'(fjv_pkg::CHG_LIMIT_RST);
         rated_frequency_r <= FW'(fjv_pkg::RATED_RST);
         supervision_window_r <= fjv_pkg::WINDOW_RST;
         lv_thresh_r <= fjv_pkg::LV_THRESH_RST;
         surge_thr_r <= fjv_pkg::SURGE_THR_RST;
         ref_period_r <= fjv_pkg::REF_PERIOD_RST;
         int_mask_r <= '0;
      end
      else if (do_wr && (|wstrb_r))
         case (awaddr_r)
            fjv_pkg::OFF_CTRL: ctrl_r <= wdata_r[4:0];
            fjv_pkg::OFF_PICKUP: pickup_r <= wdata_r[FW-1:0];
            fjv_pkg::OFF_CHG_LIMIT: freq_change_limit_r <= wdata_r[FW-1:0];
            fjv_pkg::OFF_WINDOW: supervision_window_r <= wdata_r[15:0];
            fjv_pkg::OFF_LV_THRESH: lv_thresh_r <= wdata_r[15:0];
            fjv_pkg::OFF_SURGE_THR: surge_thr_r <= wdata_r;
            fjv_pkg::OFF_REF_PERIOD: ref_period_r <= wdata_r;
            fjv_pkg::OFF_RATED: rated_frequency_r <= wdata_r[FW-1:0];
            fjv_pkg::OFF_INT_MASK: int_mask_r <= wdata_r[INT_W_C-1:0];
            default: ;
         endcase
   end
   // ****************************************
   // register reads
   // ****************************************
   always_comb
   begin
      rd_mux = 32'h0000_0000;
      rd_err = 1'b0;
      case (s_axi_araddr)
         fjv_pkg::OFF_CTRL: rd_mux = 32'(ctrl_r);
         fjv_pkg::OFF_PICKUP: rd_mux = 32'(pickup_r);
         fjv_pkg::OFF_CHG_LIMIT: rd_mux = 32'(freq_change_limit_r);
         fjv_pkg::OFF_WINDOW: rd_mux = 32'(supervision_window_r);
         fjv_pkg::OFF_LV_THRESH: rd_mux = 32'(lv_thresh_r);
         fjv_pkg::OFF_SURGE_THR: rd_mux = surge_thr_r;
         fjv_pkg::OFF_REF_PERIOD: rd_mux = ref_period_r;
         fjv_pkg::OFF_RATED: rd_mux = 32'(rated_frequency_r);
         fjv_pkg::OFF_STATUS: rd_mux = 32'({|phase_loss, st_r == fjv_pkg::FJV_LOCK,
                                            blocked, trip_r, alarm_r});
         fjv_pkg::OFF_INT_STAT: rd_mux = 32'(int_stat_r);
         fjv_pkg::OFF_INT_MASK: rd_mux = 32'(int_mask_r);
         default: rd_err = 1'b1;
      endcase
   end
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= 2'h0;
      end
      else if (do_rd)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_mux;
         s_axi_rresp <= rd_err ? 2'h2 : 2'h0;
      end
      else if (s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end
endmodule

// *** hw/fjv_pkg.sv ***
// constants, state codes and register map of the frequency jump and vector surge element
// assumes one 200 MHz clock; registers sit behind an AXI4-Lite slave
//
// What this block does
// - all three voltages low blocks evaluation
// - jump modes check pickup and change limit
// - pickup unblocked: alarm, start window same cycle
// - trip when change reaches limit in window
// - window expiry without change: no trip
// - after expiry stay locked until re-crossing
// - surge: time each cycle between zero crossings
// - cycle deviation from reference is surge angle
// - surge above threshold trips without delay
// - vote all/two/one phases; alarm and trip together
// - phase loss blocks surge tripping
// - low-voltage lockout acts before surge trip
// - surge detects mains failure within 60 ms
// - overfrequency dropout at 99.95% or 0.05% rated
// - underfrequency dropout at 100.05% or 0.05% rated
// - set holds pickup, change limit, window length
package fjv_pkg;
   // ****************************************
   // timing
   // ****************************************
   localparam int CLK_PERIOD_NS = 5;
   localparam int MS_NS = 1000000;
   localparam int CYC_PER_MS = MS_NS / CLK_PERIOD_NS;
   localparam int DETECT_MS = 60;
   localparam int DETECT_CYC = DETECT_MS * CYC_PER_MS;
   // dropout ratio 0.05 % as parts per ten thousand
   localparam int DROP_NUM = 5;
   localparam int DROP_DEN = 10000;
   // ****************************************
   // register map, byte offsets
   // ****************************************
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_PICKUP = 8'h04;
   localparam logic [7:0] OFF_CHG_LIMIT = 8'h08;
   localparam logic [7:0] OFF_WINDOW = 8'h0C;
   localparam logic [7:0] OFF_LV_THRESH = 8'h10;
   localparam logic [7:0] OFF_SURGE_THR = 8'h14;
   localparam logic [7:0] OFF_REF_PERIOD = 8'h18;
   localparam logic [7:0] OFF_RATED = 8'h1C;
   localparam logic [7:0] OFF_STATUS = 8'h20;
   localparam logic [7:0] OFF_INT_STAT = 8'h24;
   localparam logic [7:0] OFF_INT_MASK = 8'h28;
   // ctrl fields
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_VOTE_LSB = 2;
   localparam int CTRL_EN_BIT = 4;
   localparam logic [1:0] MODE_OFF = 2'h0;
   localparam logic [1:0] MODE_UNDER = 2'h1;
   localparam logic [1:0] MODE_OVER = 2'h2;
   localparam logic [1:0] MODE_SURGE = 2'h3;
   localparam logic [1:0] VOTE_ALL = 2'h0;
   localparam logic [1:0] VOTE_TWO = 2'h1;
   // status and interrupt bits
   localparam int ST_ALARM = 0;
   localparam int ST_TRIP = 1;
   localparam int ST_INHIB = 2;
   localparam int ST_LOCK = 3;
   localparam int ST_PLOSS = 4;
   localparam int INT_ALARM = 0;
   localparam int INT_TRIP = 1;
   localparam int INT_LOCK = 2;
   localparam int INT_SURGE = 3;
   localparam int INT_W = 4;
   // reset values
   localparam logic [4:0] CTRL_RST = 5'h00;
   localparam logic [15:0] PICKUP_RST = 16'h1388;
   localparam logic [15:0] CHG_LIMIT_RST = 16'h0032;
   localparam logic [15:0] WINDOW_RST = 16'h0064;
   localparam logic [15:0] LV_THRESH_RST = 16'h0100;
   localparam logic [31:0] SURGE_THR_RST = 32'h0000_7A12;
   localparam logic [31:0] REF_PERIOD_RST = 32'h003D_0900;
   localparam logic [15:0] RATED_RST = 16'h1388;
   typedef enum logic [3:0]
   {
      FJV_IDLE = 4'h1,
      FJV_WIN = 4'h2,
      FJV_TRIP = 4'h4,
      FJV_LOCK = 4'h8
   } fjv_state_e;
endpackage

// *** hw/fjv_cycle_meter.sv ***
// per-phase cycle duration meter for the vector surge check
// assumes zc_pin is an asynchronous zero-crossing square wave of one line voltage
`timescale 1ns/1ps
module fjv_cycle_meter #(
   parameter int CW = 32,
   parameter logic [31:0] MAX_CYC = 32'h00B7_1B00
)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic zc_pin,
   input wire logic [CW-1:0] ref_period,
   input wire logic [CW-1:0] surge_thresh,
   output logic new_meas,
   output logic surge
);
   logic s1_r, s2_r, s3_r, lvl_r;
   logic [CW-1:0] cnt_r;
   logic [CW-1:0] dev;
   logic zc_rise;
   // ****************************************
   // three-stage sync, change once stages 2 and 3 agree
   // ****************************************
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s1_r <= 1'b0;
         s2_r <= 1'b0;
         s3_r <= 1'b0;
      end
      else
      begin
         s1_r <= zc_pin;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         lvl_r <= 1'b0;
      else if (s2_r == s3_r)
         lvl_r <= s3_r;
   end
   assign zc_rise = s2_r & s3_r & ~lvl_r;
   // ****************************************
   // cycle timer, restarted at each rising crossing
   // ****************************************
   // saturation keeps a dead phase from wrapping back into range
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         cnt_r <= '0;
      else if (zc_rise)
         cnt_r <= CW'(1);
      else if (cnt_r < MAX_CYC[CW-1:0])
         cnt_r <= cnt_r + CW'(1);
   end
   assign dev = (cnt_r > ref_period) ? cnt_r - ref_period : ref_period - cnt_r;
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         surge <= 1'b0;
         new_meas <= 1'b0;
      end
      else
      begin
         new_meas <= zc_rise;
         if (zc_rise)
            surge <= (dev > surge_thresh);
         else if (cnt_r == MAX_CYC[CW-1:0])
            surge <= 1'b1;
      end
   end
endmodule

// *** bench/fjv_front_model.sv ***
// measuring front end stand-in: line voltages, zero-crossing squares, phase loss
// assumes the bench changes its settings just after a rising clk edge
`timescale 1ns/1ps
module fjv_front_model #(
   parameter int HALF = 500,
   parameter int JUMP = 120
)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [15:0] volt_set,
   input wire logic [2:0] jump_req,
   input wire logic [2:0] loss_set,
   output logic [15:0] line_voltage_ab,
   output logic [15:0] line_voltage_bc,
   output logic [15:0] line_voltage_ca,
   output logic zc_ab,
   output logic zc_bc,
   output logic zc_ca,
   output logic [2:0] phase_loss
);
   logic [15:0] cnt_r [3];
   logic [2:0] sq_r;
   logic [2:0] jmp_r;
   // a lost phase shows no voltage and no crossings
   assign line_voltage_ab = loss_set[0] ? 16'h0000 : volt_set;
   assign line_voltage_bc = loss_set[1] ? 16'h0000 : volt_set;
   assign line_voltage_ca = loss_set[2] ? 16'h0000 : volt_set;
   assign zc_ab = sq_r[0] & ~loss_set[0];
   assign zc_bc = sq_r[1] & ~loss_set[1];
   assign zc_ca = sq_r[2] & ~loss_set[2];
   assign phase_loss = loss_set;
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         // staggered start keeps the three crossings apart
         for (int i = 0; i < 3; i++)
            cnt_r[i] <= 16'(i * HALF / 3);
         sq_r <= 3'h0;
         jmp_r <= 3'h0;
      end
      else
      begin
         jmp_r <= jump_req;
         for (int i = 0; i < 3; i++)
         begin
            // a step pulls the next crossing forward, as a sudden phase jump would
            if (jump_req[i] && !jmp_r[i])
               cnt_r[i] <= cnt_r[i] + 16'(JUMP);
            else if (cnt_r[i] >= 16'(HALF - 1))
            begin
               cnt_r[i] <= 16'h0000;
               sq_r[i] <= ~sq_r[i];
            end
            else
               cnt_r[i] <= cnt_r[i] + 16'h0001;
         end
      end
   end
endmodule

// *** bench/fjv_freq_jump_tb.sv ***
// self-checking bench for the frequency jump and vector surge element
// assumes fjv_front_model on the measuring side and a 200 MHz clk
`timescale 1ns/1ps
module fjv_freq_jump_tb;
   typedef struct packed {logic [1:0] mode; logic [15:0] f1; logic [15:0] f2;
      logic low; logic blk; logic alarm; logic trip;} fjv_row_s;
   localparam logic [1:0] UND = fjv_pkg::MODE_UNDER;
   localparam logic [1:0] OVR = fjv_pkg::MODE_OVER;
   // words in 0.01 units; pickup 49.50 or 50.50, change limit 0.50
   localparam fjv_row_s ROWS [7] = '{
      '{UND, 16'h134C, 16'h1310, 1'b0, 1'b0, 1'b1, 1'b1},
      '{UND, 16'h134C, 16'h1324, 1'b0, 1'b0, 1'b1, 1'b0},
      '{OVR, 16'h13C4, 16'h1400, 1'b0, 1'b0, 1'b1, 1'b1},
      '{OVR, 16'h13B0, 16'h13B0, 1'b0, 1'b0, 1'b0, 1'b0},
      '{UND, 16'h134C, 16'h1310, 1'b1, 1'b0, 1'b0, 1'b0},
      '{UND, 16'h134C, 16'h1310, 1'b0, 1'b1, 1'b0, 1'b0},
      '{fjv_pkg::MODE_OFF, 16'h134C, 16'h1310, 1'b0, 1'b0, 1'b0, 1'b0}
   };
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00;
   logic [7:0] s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0000_0000;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, block_in = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, rr;
   logic [31:0] s_axi_rdata, d;
   logic [15:0] freq_set = 16'h1388, volt_set = 16'h1000;
   logic [15:0] freq_ab, freq_bc, freq_ca, line_voltage_ab, line_voltage_bc, line_voltage_ca;
   logic [2:0] jump_req = 3'h0, loss_set = 3'h0, phase_loss;
   logic zc_ab, zc_bc, zc_ca, alarm, trip, irq, a, t;
   int fail_count = 0, tests_run = 0, cyc = 0;
   // one frequency word for all three phases
   assign freq_ab = freq_set;
   assign freq_bc = freq_set;
   assign freq_ca = freq_set;
   fjv_freq_jump #(.DETECT_CYCLES(32'h0000_1000)) DUT (.*);
   fjv_front_model #(.HALF(500), .JUMP(120)) u_front (.*);
   initial
   begin
      forever #2.5 clk = ~clk;
   end
   // ceiling well above the roughly 31k cycles the sequence needs
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 90000)
      begin
         fail_count++;
         stop_test();
      end
   end
   task automatic stop_test;
      if (fail_count == 0 && tests_run > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e)
      begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic axi_wr(input logic [7:0] ad, input logic [31:0] wd);
      @(posedge clk);
      s_axi_awaddr <= ad;
      s_axi_wdata <= wd;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         @(posedge clk);
         if (s_axi_awready === 1'b1)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1)
            s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
   endtask
   task automatic axi_rd(input logic [7:0] ad);
      @(posedge clk);
      s_axi_araddr <= ad;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         @(posedge clk);
         if (s_axi_arready === 1'b1)
            s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      rr = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   task automatic watch(input int n);
      a = 1'b0;
      t = 1'b0;
      repeat (n)
      begin
         @(posedge clk);
         a = a | alarm;
         t = t | trip;
      end
   endtask
   // window 100 ms; surge reference 1000 cycles, threshold 50; mask bit 1 enables
   task automatic prep(input logic [1:0] mode, input logic [1:0] vote);
      rst_n <= 1'b0;
      freq_set <= 16'h1388;
      volt_set <= 16'h1000;
      block_in <= 1'b0;
      loss_set <= 3'h0;
      jump_req <= 3'h0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      axi_wr(fjv_pkg::OFF_PICKUP, (mode == OVR) ? 32'h0000_13BA : 32'h0000_1356);
      axi_wr(fjv_pkg::OFF_CHG_LIMIT, 32'h0000_0032);
      axi_wr(fjv_pkg::OFF_WINDOW, 32'h0000_0064);
      axi_wr(fjv_pkg::OFF_REF_PERIOD, 32'h0000_03E8);
      axi_wr(fjv_pkg::OFF_SURGE_THR, 32'h0000_0032);
      axi_wr(fjv_pkg::OFF_INT_MASK, 32'h0000_000F);
      axi_wr(fjv_pkg::OFF_CTRL, {27'h0, 1'b1, vote, mode});
   endtask
   task automatic surge(input logic [1:0] vt, input logic [2:0] jp, input logic [2:0] ls,
      input logic lo, input logic ex);
      prep(fjv_pkg::MODE_SURGE, vt);
      loss_set <= ls;
      volt_set <= lo ? 16'h0080 : 16'h1000;
      watch(2500);
      jump_req <= jp;
      watch(2500);
      // alarm and trip must agree, both seen within the 2500-cycle watch after the jump
      chk("surge", {30'h0, ex, ex}, {30'h0, a, t});
   endtask
   initial
   begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      axi_rd(fjv_pkg::OFF_PICKUP);
      chk("pickup", {16'h0000, fjv_pkg::PICKUP_RST}, d);
      axi_rd(fjv_pkg::OFF_WINDOW);
      chk("window", {16'h0000, fjv_pkg::WINDOW_RST}, d);
      axi_rd(8'h3C);
      chk("unmapped", 32'h2, {30'h0, rr});
      foreach (ROWS[i])
      begin
         prep(ROWS[i].mode, fjv_pkg::VOTE_ALL);
         volt_set <= ROWS[i].low ? 16'h0080 : 16'h1000;
         block_in <= ROWS[i].blk;
         watch(20);
         freq_set <= ROWS[i].f1;
         watch(8);
         chk("alarm", {31'h0, ROWS[i].alarm}, {31'h0, a});
         freq_set <= ROWS[i].f2;
         watch(40);
         chk("trip", {31'h0, ROWS[i].trip}, {31'h0, t});
      end
      prep(UND, fjv_pkg::VOTE_ALL);
      freq_set <= 16'h134C;
      watch(8);
      freq_set <= 16'h1310;
      watch(40);
      chk("irq", 32'h1, {31'h0, irq});
      axi_rd(fjv_pkg::OFF_INT_STAT);
      chk("int stat", 32'h3, d & 32'h0000_0003);
      watch(4);
      chk("irq clear", 32'h0, {31'h0, irq});
      // 49.52 sits inside the 0.05 percent band, 49.60 beyond it
      freq_set <= 16'h1358;
      watch(20);
      chk("held", 32'h3, {30'h0, trip, alarm});
      freq_set <= 16'h1360;
      watch(20);
      chk("dropout", 32'h0, {30'h0, trip, alarm});
      axi_wr(fjv_pkg::OFF_INT_MASK, 32'h0000_0000);
      axi_rd(fjv_pkg::OFF_INT_STAT);
      freq_set <= 16'h134C;
      watch(20);
      chk("masked", 32'h2, {30'h0, alarm, irq});
      prep(OVR, fjv_pkg::VOTE_ALL);
      freq_set <= 16'h13C4;
      watch(8);
      freq_set <= 16'h13B8;
      watch(20);
      chk("over held", 32'h1, {31'h0, alarm});
      freq_set <= 16'h13B0;
      watch(20);
      chk("over drop", 32'h0, {31'h0, alarm});
      prep(UND, fjv_pkg::VOTE_ALL);
      // zero-length window expires at once
      axi_wr(fjv_pkg::OFF_WINDOW, 32'h0000_0000);
      freq_set <= 16'h134C;
      watch(300);
      freq_set <= 16'h12C0;
      watch(40);
      chk("expired", 32'h0, {31'h0, t});
      surge(2'h2, 3'h1, 3'h0, 1'b0, 1'b1);
      surge(fjv_pkg::VOTE_TWO, 3'h1, 3'h0, 1'b0, 1'b0);
      surge(fjv_pkg::VOTE_TWO, 3'h3, 3'h0, 1'b0, 1'b1);
      surge(fjv_pkg::VOTE_ALL, 3'h7, 3'h0, 1'b0, 1'b1);
      surge(2'h2, 3'h7, 3'h1, 1'b0, 1'b0);
      surge(2'h2, 3'h7, 3'h0, 1'b1, 1'b0);
      stop_test();
   end
endmodule
